// ===== include/mem_ecc_pkg.sv
// constants and carrier types for the memory ecc, isolation and test block
package mem_ecc_pkg;
  localparam int PORTS       = 4;
  localparam int PORT_DATA_W = 16;
  localparam int PORT_CHK_W  = 2;
  localparam int PORT_W      = 18;
  localparam int DATA_W      = 64;
  localparam int CHK_W       = 8;
  localparam int LINE_W      = 32;
  localparam int ROWS        = 8;
  localparam int ROW_W       = 3;
  localparam int SYMS        = 8;
  localparam int SYM_W       = 3;
  localparam int TEST_BUFFERS = 32;
  localparam int BUF_AW      = 5;
  localparam logic [LINE_W-1:0] TEST_STRIDE = 32'h0000_0020;
  // main channel ports whose symbol g is inverted to poison a write
  localparam int POISON_PORT_A = 1;
  localparam int POISON_PORT_B = 3;
  localparam logic [PORT_W-1:0] G_SYMBOL_MASK = 18'h30000;
  // line address bit that picks the ddr branch behind a hub
  localparam int LINE_CH_BIT = 0;
  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_LOG        = 8'h04;
  localparam logic [7:0] REG_PROGRESS   = 8'h08;
  localparam logic [7:0] REG_RANGE_BASE = 8'h40;
  localparam logic [7:0] REG_RANGE_TOP  = 8'h44;
  localparam logic [7:0] REG_RANGE_END  = 8'h80;
  localparam int RANGE_SHIFT = 3;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_X8_BIT  = 1;
  localparam int CTRL_SEL_LSB = 4;
  // locator log fields
  localparam int LOG_VALID_BIT = 0;
  localparam int LOG_UNCOR_BIT = 1;
  localparam int LOG_CH_BIT    = 2;
  localparam int LOG_DEV_LSB   = 4;
  localparam int LOG_LOC_LSB   = 8;
  localparam int LOG_LOCV_BIT  = 11;
  localparam int LOG_PORT_LSB  = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic                      poison;
    logic [LINE_W-1:0]         addr;
    logic [DATA_W-1:0]         data;
  } cpu_req_type;

  typedef struct packed {
    logic                      valid;
    logic                      err;
    logic [DATA_W-1:0]         data;
  } cpu_rsp_type;

  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic                      engine;
    logic [LINE_W-1:0]         addr;
    logic [ROW_W-1:0]          row;
    logic [SYMS*SYM_W-1:0]     symbol_map;
    logic [PORTS*PORT_W-1:0]   port;
  } mem_req_type;

  typedef struct packed {
    logic                      valid;
    logic                      engine;
    logic [LINE_W-1:0]         addr;
    logic [PORTS*PORT_W-1:0]   port;
  } mem_rsp_type;

  typedef enum logic [2:0] {
    ENG_IDLE     = 3'h0,
    ENG_ISSUE_RD = 3'h1,
    ENG_WAIT_RD  = 3'h3,
    ENG_RD_BUF   = 3'h2,
    ENG_ISSUE_WR = 3'h6
  } eng_state_type;
endpackage : mem_ecc_pkg

// ===== verif/hub_model.sv
// model of the four memory hubs behind the ports
`timescale 1ns/100ps
`default_nettype none
module hub_model (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire mem_ecc_pkg::mem_req_type mem_req,
  output logic                         mem_ready,
  output mem_ecc_pkg::mem_rsp_type     mem_rsp,
  input wire logic [71:0]              flip,
  input wire logic                     slow
);
  logic [71:0]              store [logic [31:0]];
  mem_ecc_pkg::mem_rsp_type pipe [3];
  logic [1:0]               cnt;
  // stall one cycle in four when slow
  assign mem_ready = !(slow && cnt == 2'h3);
  // idle answer lines show the inverse
  always_comb begin
    mem_rsp = pipe[2].valid ? pipe[2] : ~pipe[2];
    mem_rsp.valid = pipe[2].valid;
  end
  // three cycle reads, raw pin images stored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 2'h0;
      foreach (pipe[i]) pipe[i] <= '0;
    end else begin
      cnt <= cnt + 2'h1;
      pipe[1] <= pipe[0];
      pipe[2] <= pipe[1];
      pipe[0].valid <= 1'b0;
      if (mem_req.valid && mem_ready && mem_req.write) store[mem_req.addr] = mem_req.port;
      if (mem_req.valid && mem_ready && !mem_req.write) begin
        pipe[0] <= '{1'b1, mem_req.engine, mem_req.addr,
          (store.exists(mem_req.addr) ? store[mem_req.addr] : 72'h0) ^ flip};
      end
    end
  end
endmodule : hub_model
`default_nettype wire

// ===== verif/mem_ecc_test_monitor.sv
// assertions for the memory ecc, isolation and test block
`timescale 1ns/100ps
`default_nettype none
module mem_ecc_test_monitor (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     hsel,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire logic [31:0]              hrdata,
  input wire mem_ecc_pkg::cpu_req_type cpu_req,
  input wire mem_ecc_pkg::cpu_rsp_type cpu_rsp,
  input wire logic                     cpu_ack,
  input wire mem_ecc_pkg::mem_req_type mem_req,
  input wire logic                     mem_ready,
  input wire mem_ecc_pkg::mem_rsp_type mem_rsp,
  input wire logic                     test_buffers_held
);
  logic rd_phase;
  logic zero_wr;
  // read address phase; cpu write of a zero line
  assign rd_phase = hsel && hready && htrans == mem_ecc_pkg::HTRANS_NONSEQ && !hwrite;
  assign zero_wr  = mem_req.valid && mem_req.write && !mem_req.engine
                    && (mem_req.port & {4{18'h0ffff}}) == 72'h0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_bus_a: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  rd_hold_a: assert property (!rd_phase |=> $stable(hrdata))
    else $error("hrdata moved");
  ack_cause_a: assert property (cpu_ack |-> $past(cpu_req.valid) && mem_req.valid)
    else $error("stray ack");
  req_hold_a: assert property (mem_req.valid && !mem_ready |=> mem_req.valid && $stable(mem_req))
    else $error("request not held");
  rsp_follow_a: assert property (mem_rsp.valid && !mem_rsp.engine |=> cpu_rsp.valid)
    else $error("answer lost");
  rsp_cause_a: assert property (cpu_rsp.valid |-> $past(mem_rsp.valid) && !$past(mem_rsp.engine))
    else $error("stray answer");
  zero_chk_a: assert property (
    zero_wr |-> mem_req.port[17:16] == 2'h3 && mem_req.port[53:52] == 2'h3)
    else $error("checkbits not inverted");
  ecc_parity_a: assert property (
    mem_req.valid && mem_req.write |-> ^mem_req.port == 1'b0)
    else $error("illegal ecc");
  engine_held_a: assert property (
    mem_req.valid && mem_req.engine |-> test_buffers_held)
    else $error("buffers not held");
endmodule : mem_ecc_test_monitor
`default_nettype wire

// ===== verif/mem_ecc_test_tb.sv
// testbench for the memory ecc, isolation and test block
`timescale 1ns/100ps
`default_nettype none
module mem_ecc_test_tb;
  logic                     hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic                     cpu_ack, mem_ready, held, slow;
  logic [31:0]              haddr, hwdata, hrdata, rd;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [71:0]              flip, seen_port;
  logic [63:0]              seed [32];
  mem_ecc_pkg::cpu_req_type cpu_req;
  mem_ecc_pkg::cpu_rsp_type cpu_rsp, rsp;
  mem_ecc_pkg::mem_req_type mem_req;
  mem_ecc_pkg::mem_rsp_type mem_rsp;
  int                       mismatches = 0;
  int                       check_count = 0;
  localparam logic [71:0] FLIPS [3] = '{72'h20, 72'h20, 72'hc_0000};
  localparam logic [31:0] MASKS [3] = '{32'h3f0f, 32'h80f, 32'h80f};
  localparam logic [31:0] LOGS  [3] = '{32'h2d05, 32'h5, 32'h7};
  localparam logic [7:0]  CTRL = mem_ecc_pkg::REG_CTRL, LOG = mem_ecc_pkg::REG_LOG;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  mem_ecc_test DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_ack(cpu_ack),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp), .test_buffers_held(held));
  hub_model hubs (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rsp(mem_rsp), .flip(flip), .slow(slow));
  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // single-word bus transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= mem_ecc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // line request held until ack, then read answer
  task automatic cpu(input logic w, input logic p, input logic [31:0] a, input logic [63:0] d);
    int n;
    @(posedge hclk);
    cpu_req <= '{1'b1, w, p, a, d};
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 900);
    seen_port = mem_req.port;
    cpu_req.valid <= 1'b0;
    n = 0;
    while (!w && cpu_rsp.valid !== 1'b1 && n < 900) begin
      @(posedge hclk);
      n++;
    end
    rsp = cpu_rsp;
  endtask : cpu
  // main sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, slow} = '0;
    {haddr, hwdata, htrans, flip, cpu_req} = '0;
    hsize = mem_ecc_pkg::HSIZE_WORD;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, CTRL, 32'h0);
    check(64'(rd), 64'h0); // idle control
    ahb(1'b1, mem_ecc_pkg::REG_RANGE_END, 32'hffff_ffff);
    ahb(1'b0, mem_ecc_pkg::REG_RANGE_END, 32'h0);
    check(64'(rd), 64'h0);
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      cpu(1'b1, p[0], 32'h10, 64'h0);
      for (int q = 0; q < 4; q++) begin
        check(64'(seen_port[q*18 +: 18]), 64'({2'h3, 16'h0} ^ ((p == 1 && q % 2 == 1) ?
          mem_ecc_pkg::G_SYMBOL_MASK : 18'h0))); // pin image
      end
    end
    $display("write image test done");
    cpu(1'b0, 1'b0, 32'h20, 64'h0);
    check(64'(rsp.err), 64'h1); // silent line
    ahb(1'b0, LOG, 32'h0);
    check(64'(rd & 32'h803), 64'h3); // row only
    ahb(1'b1, LOG, 32'h1);
    $display("silent line test done");
    cpu(1'b1, 1'b0, 32'h31, 64'h0123_4567_89ab_cdef);
    cpu(1'b0, 1'b0, 32'h31, 64'h0);
    check(rsp.data, 64'h0123_4567_89ab_cdef); // round trip
    // correctable, x8 correctable, two-bit error
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, CTRL, {30'h0, k == 1, 1'b0});
      flip <= FLIPS[k];
      cpu(1'b0, 1'b0, 32'h31, 64'h0);
      flip <= 72'h0;
      check(64'(rsp.err), 64'(k == 2)); // detection
      ahb(1'b0, LOG, 32'h0);
      check(64'(rd & MASKS[k]), 64'(LOGS[k])); // log fields
      ahb(1'b1, LOG, 32'h1);
    end
    $display("isolation log test done");
    // range 0 is a decoy, range 1 is tested
    ahb(1'b1, mem_ecc_pkg::REG_RANGE_BASE, 32'h200);
    ahb(1'b1, mem_ecc_pkg::REG_RANGE_TOP, 32'h23f);
    ahb(1'b1, mem_ecc_pkg::REG_RANGE_BASE + 8'h8, 32'h100);
    ahb(1'b1, mem_ecc_pkg::REG_RANGE_TOP + 8'h8, 32'h13f);
    slow <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 32; i++) begin
        seed[i] = {32'(i), 32'(s)} ^ {64{s[0]}};
        cpu(1'b1, 1'b0, 32'h100 + 32'(i), seed[i]);
      end
      ahb(1'b1, CTRL, 32'h11);
      cpu(1'b0, 1'b0, 32'h31, 64'h0);
      check(rsp.data, 64'h0123_4567_89ab_cdef); // outside traffic
      check(64'(held), 64'h1); // buffers held
      rd = 32'h1;
      for (int n = 0; n < 400 && rd[0]; n++) ahb(1'b0, CTRL, 32'h0);
      check(64'(rd[0]), 64'h0); // run cleared
      check(64'(held), 64'h0); // buffers freed
      // end of range against the seed
      for (int i = 32; i < 64; i++) begin
        cpu(1'b0, 1'b0, 32'h100 + 32'(i), 64'h0);
        check(rsp.data, seed[i % 32]); // copied line
        check(64'(rsp.err), 64'h0); // legal ecc
      end
      $display("memory test pass %0d done", s);
    end
    results();
  end
  // cut a hang short
  initial begin
    #(20 * 30000);
    mismatches++;
    results();
  end
endmodule : mem_ecc_test_tb
bind mem_ecc_test mem_ecc_test_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_ack(cpu_ack),
  .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp),
  .test_buffers_held(test_buffers_held));
`default_nettype wire

// ===== verilog/mem_ecc_test.sv
// memory ecc rotation, poisoning, error isolation log and test engine
//
// Function
// (RULE1) mixed symbols rotate devices over eight addresses
// (RULE2) cross-channel codeword check flags wrong data
// (RULE3) invert checkbits on write and read
// (RULE4) poison symbol g on ports 1, 3
// (RULE5) x8 parts: no single-device isolation claim
// (RULE6) packet comes from one dimm row
// (RULE7) log branch channel and chip select
// (RULE8) correctable errors log the symbol locator
// (RULE9) uncorrectable errors log row only
// (RULE10) test runs autonomously, leaves legal ecc
// (RULE11) range select and run bit start test
// (RULE12) test holds 32 buffers, quotas reduced
// (RULE13) engine issues only local memory accesses
// (RULE14) test every address of range, io overlap
// (RULE15) software seeds first 32 lines first
// (RULE16) run bit replicates seed through range
// (RULE17) requests outside test range keep flowing
// (RULE18) run bit cleared when test finishes
// (RULE19) software compares range end with seed
// (RULE20) software repeats with several seed patterns
// (RULE21) eight dimm rows, each own technology
// (RULE22) copy each line one block further on
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mem_ecc_test (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  input  wire mem_ecc_pkg::cpu_req_type    cpu_req,
  output mem_ecc_pkg::cpu_rsp_type         cpu_rsp,
  output logic                             cpu_ack,
  output mem_ecc_pkg::mem_req_type         mem_req,
  input  wire logic                        mem_ready,
  input  wire mem_ecc_pkg::mem_rsp_type    mem_rsp,
  output logic                             test_buffers_held
);
  localparam int LW = mem_ecc_pkg::LINE_W;
  localparam int DW = mem_ecc_pkg::DATA_W;
  localparam int PW = mem_ecc_pkg::PORT_W;
  localparam int NP = mem_ecc_pkg::PORTS;
  localparam int RANGE_SHIFT_HI = mem_ecc_pkg::RANGE_SHIFT + mem_ecc_pkg::ROW_W - 1;

  // checkbits: bit j covers data bits j, j+8, ... across all four ports
  function automatic logic [mem_ecc_pkg::CHK_W-1:0] encode(input logic [DW-1:0] d);
    logic [mem_ecc_pkg::CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DW; i++) begin
      c[i % mem_ecc_pkg::CHK_W] = c[i % mem_ecc_pkg::CHK_W] ^ d[i];
    end
    return c;
  endfunction : encode

  // device driving each symbol, rotated by low address bits
  function automatic logic [mem_ecc_pkg::SYMS*mem_ecc_pkg::SYM_W-1:0] rotate_map(
    input logic [mem_ecc_pkg::SYM_W-1:0] rot);
    logic [mem_ecc_pkg::SYMS*mem_ecc_pkg::SYM_W-1:0] m;
    m = '0;
    for (int s = 0; s < mem_ecc_pkg::SYMS; s++) begin
      m[s*mem_ecc_pkg::SYM_W +: mem_ecc_pkg::SYM_W] = rot + s[mem_ecc_pkg::SYM_W-1:0];
    end
    return m;
  endfunction : rotate_map

  // range containment test
  function automatic logic in_range(input logic [LW-1:0] a, input logic [LW-1:0] lo,
                                    input logic [LW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // register state
  logic                               run;
  logic                               x8_mode;
  logic [mem_ecc_pkg::ROW_W-1:0]      range_sel;
  logic [LW-1:0]                      range_base [mem_ecc_pkg::ROWS];
  logic [LW-1:0]                      range_top  [mem_ecc_pkg::ROWS];
  logic [31:0]                        log_word;
  logic                               wr_pend;
  logic [7:0]                         wr_addr;
  // engine state
  mem_ecc_pkg::eng_state_type         state;
  logic [LW-1:0]                      cur;
  logic [DW-1:0]                      buf_rd_data;
  logic                               buf_wr_en;
  logic [DW-1:0]                      rsp_data;
  logic [mem_ecc_pkg::CHK_W-1:0]      rsp_chk;
  logic [mem_ecc_pkg::CHK_W-1:0]      syndrome;
  logic                               slot_free;
  logic                               eng_issue;
  logic                               cpu_blocked;
  logic                               cpu_issue;
  logic [mem_ecc_pkg::ROW_W-1:0]      cpu_row;
  logic [mem_ecc_pkg::ROW_W-1:0]      rsp_row;
  logic                               last_line;

  // row decode of a cpu request and of a returning response
  always_comb begin
    cpu_row = '0;
    rsp_row = '0;
    for (int r = 0; r < mem_ecc_pkg::ROWS; r++) begin
      if (in_range(cpu_req.addr, range_base[r], range_top[r])) begin
        cpu_row = r[mem_ecc_pkg::ROW_W-1:0];
      end
      if (in_range(mem_rsp.addr, range_base[r], range_top[r])) begin
        rsp_row = r[mem_ecc_pkg::ROW_W-1:0];
      end
    end
  end

  // (RULE3) un-invert checkbits on sampling
  always_comb begin
    rsp_data = '0;
    rsp_chk  = '0;
    for (int p = 0; p < NP; p++) begin
      rsp_data[p*mem_ecc_pkg::PORT_DATA_W +: mem_ecc_pkg::PORT_DATA_W] =
        mem_rsp.port[p*PW +: mem_ecc_pkg::PORT_DATA_W];
      rsp_chk[p*mem_ecc_pkg::PORT_CHK_W +: mem_ecc_pkg::PORT_CHK_W] =
        ~mem_rsp.port[p*PW + mem_ecc_pkg::PORT_DATA_W +: mem_ecc_pkg::PORT_CHK_W];
    end
  end

  // (RULE2) checkbits span all channels
  assign syndrome = encode(rsp_data) ^ rsp_chk;

  // issue slot, engine before processor
  assign slot_free = !mem_req.valid || mem_ready;
  assign eng_issue = slot_free &&
                     (state == mem_ecc_pkg::ENG_ISSUE_RD || state == mem_ecc_pkg::ENG_ISSUE_WR);
  // (RULE17) only requests inside the range under test wait
  assign cpu_blocked = run && in_range(cpu_req.addr, range_base[range_sel], range_top[range_sel]);
  assign cpu_issue   = slot_free && !eng_issue && cpu_req.valid && !cpu_ack && !cpu_blocked;
  assign last_line   = (cur + mem_ecc_pkg::TEST_STRIDE) >= range_top[range_sel];
  assign buf_wr_en   = mem_rsp.valid && mem_rsp.engine && state == mem_ecc_pkg::ENG_WAIT_RD;

  // engine line buffer
  mem_line_buf u_buf (
    .hclk    (hclk),
    .wr_en   (buf_wr_en),
    .wr_addr (cur[mem_ecc_pkg::BUF_AW-1:0]),
    .wr_data (rsp_data),
    .rd_addr (cur[mem_ecc_pkg::BUF_AW-1:0]),
    .rd_data (buf_rd_data)
  );

  // ahb address phase capture and zero-wait answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready) begin
      wr_pend <= hsel && htrans == mem_ecc_pkg::HTRANS_NONSEQ && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // ahb read data, loaded in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans == mem_ecc_pkg::HTRANS_NONSEQ && !hwrite) begin
      hrdata <= '0;
      if (haddr[7:0] == mem_ecc_pkg::REG_CTRL) begin
        hrdata[mem_ecc_pkg::CTRL_RUN_BIT] <= run;
        hrdata[mem_ecc_pkg::CTRL_X8_BIT]  <= x8_mode;
        hrdata[mem_ecc_pkg::CTRL_SEL_LSB +: mem_ecc_pkg::ROW_W] <= range_sel;
      end else if (haddr[7:0] == mem_ecc_pkg::REG_LOG) begin
        hrdata <= log_word;
      end else if (haddr[7:0] == mem_ecc_pkg::REG_PROGRESS) begin
        hrdata <= cur;
      end else if (haddr[7:0] >= mem_ecc_pkg::REG_RANGE_BASE &&
                   haddr[7:0] <  mem_ecc_pkg::REG_RANGE_END) begin
        hrdata <= haddr[2] ? range_top[haddr[RANGE_SHIFT_HI:mem_ecc_pkg::RANGE_SHIFT]]
                           : range_base[haddr[RANGE_SHIFT_HI:mem_ecc_pkg::RANGE_SHIFT]];
      end
    end
  end

  // (RULE21) one base and top per dimm row, eight rows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int r = 0; r < mem_ecc_pkg::ROWS; r++) begin
        range_base[r] <= '0;
        range_top[r]  <= '0;
      end
    end else if (wr_pend && wr_addr >= mem_ecc_pkg::REG_RANGE_BASE &&
                 wr_addr < mem_ecc_pkg::REG_RANGE_END && !run) begin
      if (wr_addr[2]) begin
        range_top[wr_addr[RANGE_SHIFT_HI:mem_ecc_pkg::RANGE_SHIFT]]  <= hwdata;
      end else begin
        range_base[wr_addr[RANGE_SHIFT_HI:mem_ecc_pkg::RANGE_SHIFT]] <= hwdata;
      end
    end
  end

  // control register: range select, x8 mode, run bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run       <= 1'b0;
      x8_mode   <= 1'b0;
      range_sel <= '0;
    end else if (state == mem_ecc_pkg::ENG_ISSUE_WR && eng_issue && last_line) begin
      // (RULE18) clear run bit at completion
      run <= 1'b0;
    end else if (wr_pend && wr_addr == mem_ecc_pkg::REG_CTRL && !run) begin
      // (RULE11) select range and start
      run       <= hwdata[mem_ecc_pkg::CTRL_RUN_BIT];
      x8_mode   <= hwdata[mem_ecc_pkg::CTRL_X8_BIT];
      range_sel <= hwdata[mem_ecc_pkg::CTRL_SEL_LSB +: mem_ecc_pkg::ROW_W];
    end
  end

  // (RULE12) flag the 32 held buffers while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_buffers_held <= 1'b0;
    end else begin
      test_buffers_held <= run || (mem_req.valid && mem_req.engine && !mem_ready);
    end
  end

  // test engine sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= mem_ecc_pkg::ENG_IDLE;
      cur   <= '0;
    end else begin
      case (state)
        mem_ecc_pkg::ENG_IDLE: begin
          // (RULE10) starts on its own
          if (run) begin
            cur   <= range_base[range_sel];
            state <= mem_ecc_pkg::ENG_ISSUE_RD;
          end
        end
        mem_ecc_pkg::ENG_ISSUE_RD: begin
          if (eng_issue) begin
            state <= mem_ecc_pkg::ENG_WAIT_RD;
          end
        end
        mem_ecc_pkg::ENG_WAIT_RD: begin
          if (buf_wr_en) begin
            state <= mem_ecc_pkg::ENG_RD_BUF;
          end
        end
        mem_ecc_pkg::ENG_RD_BUF: begin
          state <= mem_ecc_pkg::ENG_ISSUE_WR;
        end
        mem_ecc_pkg::ENG_ISSUE_WR: begin
          // (RULE14) every line to the range top, io overlap included
          if (eng_issue) begin
            cur   <= cur + 32'h0000_0001;
            state <= last_line ? mem_ecc_pkg::ENG_IDLE : mem_ecc_pkg::ENG_ISSUE_RD;
          end
        end
        default: begin
          state <= mem_ecc_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // request register towards the four hubs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= '0;
    end else if (slot_free) begin
      mem_req.valid <= eng_issue || cpu_issue;
      if (eng_issue) begin
        // (RULE13) engine addresses stay inside a local range
        mem_req.engine <= 1'b1;
        mem_req.write  <= state == mem_ecc_pkg::ENG_ISSUE_WR;
        // (RULE22) read line, write it one block further on
        mem_req.addr   <= (state == mem_ecc_pkg::ENG_ISSUE_WR) ?
                          cur + mem_ecc_pkg::TEST_STRIDE : cur;
        // (RULE6) whole packet from the selected row
        mem_req.row    <= range_sel;
        // (RULE1) symbol to device rotation
        mem_req.symbol_map <= rotate_map(cur[mem_ecc_pkg::SYM_W-1:0]);
        // (RULE16) seed copied forward with fresh legal checkbits
        for (int p = 0; p < NP; p++) begin
          mem_req.port[p*PW +: PW] <= {2'(~encode(buf_rd_data) >> (p*mem_ecc_pkg::PORT_CHK_W)),
                                       buf_rd_data[p*mem_ecc_pkg::PORT_DATA_W +:
                                        mem_ecc_pkg::PORT_DATA_W]};
        end
      end else if (cpu_issue) begin
        mem_req.engine     <= 1'b0;
        mem_req.write      <= cpu_req.write;
        mem_req.addr       <= cpu_req.addr;
        mem_req.row        <= cpu_row;
        mem_req.symbol_map <= rotate_map(cpu_req.addr[mem_ecc_pkg::SYM_W-1:0]);
        for (int p = 0; p < NP; p++) begin
          // (RULE3) checkbits inverted on the way out
          // (RULE4) poison flips symbol g on ports 1 and 3
          mem_req.port[p*PW +: PW] <=
            {2'(~encode(cpu_req.data) >> (p*mem_ecc_pkg::PORT_CHK_W)),
             cpu_req.data[p*mem_ecc_pkg::PORT_DATA_W +: mem_ecc_pkg::PORT_DATA_W]} ^
            ((cpu_req.poison && (p == mem_ecc_pkg::POISON_PORT_A ||
                                 p == mem_ecc_pkg::POISON_PORT_B)) ?
             mem_ecc_pkg::G_SYMBOL_MASK : '0);
        end
      end
    end
  end

  // processor acknowledge and read return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_ack <= 1'b0;
      cpu_rsp <= '0;
    end else begin
      cpu_ack       <= cpu_issue;
      cpu_rsp.valid <= mem_rsp.valid && !mem_rsp.engine;
      cpu_rsp.data  <= rsp_data;
      cpu_rsp.err   <= mem_rsp.valid && !$onehot0(syndrome);
    end
  end

  // isolation log: first error held, a software clear of a held log wins over a new error in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      log_word <= '0;
    end else if (mem_rsp.valid && syndrome != '0 && !log_word[mem_ecc_pkg::LOG_VALID_BIT]) begin
      log_word <= '0;
      log_word[mem_ecc_pkg::LOG_VALID_BIT] <= 1'b1;
      // (RULE7) branch channel and chip select of the side
      log_word[mem_ecc_pkg::LOG_CH_BIT] <= mem_rsp.addr[mem_ecc_pkg::LINE_CH_BIT];
      log_word[mem_ecc_pkg::LOG_DEV_LSB +: mem_ecc_pkg::ROW_W] <= rsp_row;
      if ($onehot(syndrome) && !x8_mode) begin
        // (RULE8) single symbol: locator and its main channel
        for (int j = 0; j < mem_ecc_pkg::SYMS; j++) begin
          if (syndrome[j]) begin
            log_word[mem_ecc_pkg::LOG_LOC_LSB +: mem_ecc_pkg::SYM_W] <= j[2:0];
            log_word[mem_ecc_pkg::LOG_PORT_LSB +: 2] <= j[2:1];
          end
        end
        log_word[mem_ecc_pkg::LOG_LOCV_BIT] <= 1'b1;
      end else begin
        // (RULE9) row only, locator left invalid
        // (RULE5) x8 parts never get a locator
        log_word[mem_ecc_pkg::LOG_UNCOR_BIT] <= !$onehot(syndrome);
      end
    end else if (wr_pend && wr_addr == mem_ecc_pkg::REG_LOG &&
                 hwdata[mem_ecc_pkg::LOG_VALID_BIT]) begin
      log_word <= '0;
    end
  end
endmodule : mem_ecc_test
`default_nettype wire

// ===== verilog/mem_line_buf.sv
// line buffer held by the test engine, registered read data
`timescale 1ns/100ps
`default_nettype none
module mem_line_buf (
  input  wire logic                                hclk,
  input  wire logic                                wr_en,
  input  wire logic [mem_ecc_pkg::BUF_AW-1:0]      wr_addr,
  input  wire logic [mem_ecc_pkg::DATA_W-1:0]      wr_data,
  input  wire logic [mem_ecc_pkg::BUF_AW-1:0]      rd_addr,
  output logic      [mem_ecc_pkg::DATA_W-1:0]      rd_data
);
  logic [mem_ecc_pkg::DATA_W-1:0] mem [mem_ecc_pkg::TEST_BUFFERS];

  // write port
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge hclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : mem_line_buf
`default_nettype wire
